// ==== hdl/stop_motion_command_handler.sv ====
// stop-motion command interpreter for the drive's cyclic link
// assumes cmd_valid_in is a one-cycle strobe from same-clock frame logic
// How it works
// - command code 25H selects stop motion
// - accepted command decelerates or cuts output, then holds position
// - act only in link phases 2 and 3
// - phase 1 raises warning A.95A, ignored
// - option field is captured and applied
// - output-complete flag marks stop finished
// - cancel pending latch, positioning, servo latches
// - abort home-return latch and alignment
// - selector 0 follows deceleration parameter
// - selector 1 cuts output immediately
`timescale 1ns/1ps
module stop_motion_command_handler (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic cmd_valid_in,
  input wire stop_motion_pkg::cmd_s cmd_in,
  input wire logic [1:0] link_phase_in,
  input wire logic [15:0] speed_in,
  input wire logic [15:0] decel_param_in,
  input wire logic [7:0] status_in,
  output logic [15:0] speed_ref_out,
  output logic output_cut_out,
  output logic output_complete_flag_out,
  output logic latch_cancel_out,
  output logic home_return_abort_out,
  output logic [7:0] option_out,
  output logic rsp_valid_out,
  output stop_motion_pkg::rsp_s rsp_out
);
  import stop_motion_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_STOP = 3'b010,
    ST_HOLD = 3'b100
  } state_e;

  state_e state;
  logic is_stop_cmd;
  logic phase_ok;
  logic accept;
  logic reject;
  logic ramp_start;
  logic ramp_done;
  logic [15:0] ramp_speed;
  logic method;
  logic ramp_finished;

  ////////////////////////////////////////////////////////////////////////
  assign is_stop_cmd = cmd_valid_in && cmd_in.code == CMD_STOP_MOTION;
  assign phase_ok = link_phase_in == PHASE_2 ||
                    link_phase_in == PHASE_3;
  assign accept = is_stop_cmd && phase_ok;
  assign reject = is_stop_cmd && !phase_ok;
  // a done left over from a cut ramp must not end the restarted stop
  assign ramp_finished = ramp_done && !ramp_start && !accept;

  stop_ramp u_ramp (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .start_in(ramp_start),
    .immediate_in(method),
    .speed_in(speed_in),
    .decel_in(decel_param_in),
    .speed_out(ramp_speed),
    .done_out(ramp_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // the ramp starts a cycle after accept so the selector is registered
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      ramp_start <= 1'b0;
      method <= STOP_DECEL;
      option_out <= RESET_BYTE;
    end else begin
      ramp_start <= accept;
      if (accept) begin
        method <= cmd_in.stop_method_select;
        option_out <= cmd_in.option;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (accept) begin
            state <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (ramp_finished) begin
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // only a repeat stop command leaves hold; it restarts the stop
          if (accept) begin
            state <= ST_STOP;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      speed_ref_out <= 16'h0000;
      output_cut_out <= 1'b0;
      output_complete_flag_out <= 1'b1;
    end else begin
      speed_ref_out <= (state == ST_IDLE) ? speed_in : ramp_speed;
      if (accept) begin
        output_complete_flag_out <= 1'b0;
        output_cut_out <= 1'b0;
      end else if (ramp_finished) begin
        output_complete_flag_out <= 1'b1;
        output_cut_out <= method == STOP_IMMEDIATE;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      latch_cancel_out <= 1'b0;
      home_return_abort_out <= 1'b0;
    end else begin
      latch_cancel_out <= accept;
      home_return_abort_out <= accept;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      rsp_valid_out <= 1'b0;
      rsp_out <= '0;
    end else begin
      rsp_valid_out <= is_stop_cmd;
      if (is_stop_cmd) begin
        rsp_out.code <= cmd_in.code;
        rsp_out.alarm <= reject ? WARN_CMD_1 : WARN_NONE;
        rsp_out.status <= status_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_phase1_ignored: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    reject && state == ST_IDLE |=> state == ST_IDLE)
    else $error("stop accepted in phase 1");

  a_warn_code: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    reject |=> rsp_valid_out && rsp_out.alarm == WARN_CMD_1)
    else $error("missing phase 1 warning");

  // every cancel pulse, back to back ones too, needs a legal phase
  a_accept_phase: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    latch_cancel_out |->
    $past(link_phase_in) == PHASE_2 || $past(link_phase_in) == PHASE_3)
    else $error("accepted outside phases 2 and 3");

  a_latch_cancel: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    accept |=> latch_cancel_out && home_return_abort_out)
    else $error("latch not cancelled");

  a_home_abort: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    home_return_abort_out |-> !output_complete_flag_out)
    else $error("home return abort without a stop");

  a_flag_drops: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    accept |=> !output_complete_flag_out)
    else $error("complete flag not cleared");

  a_cut_fast: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (accept && cmd_in.stop_method_select == STOP_IMMEDIATE) ##1
    (!accept)[*2] |=> output_complete_flag_out && output_cut_out)
    else $error("immediate stop too slow");

  a_echo_code: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    is_stop_cmd |=> rsp_out.code == CMD_STOP_MOTION)
    else $error("response code not echoed");

  a_option_kept: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    accept |=> option_out == $past(cmd_in.option))
    else $error("option not captured");

  a_decel_hold: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    state == ST_HOLD |-> ramp_speed == 16'h0000)
    else $error("hold with nonzero speed");

  // a restarted ramp must not report the old ramp's completion
  a_restart_kept: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    ramp_start |=> !output_complete_flag_out)
    else $error("stale done ended a restarted stop");

  a_hold_flag: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    state == ST_HOLD |-> output_complete_flag_out)
    else $error("holding without complete flag");

  a_cut_decel: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    ramp_finished && method == STOP_DECEL |=> !output_cut_out)
    else $error("output cut after a ramped stop");
endmodule

// ==== hdl/stop_motion_pkg.sv ====
// constants and carriers for the stop-motion command handler
// assumes one system clock and a frame-level command strobe from the link
package stop_motion_pkg;
  localparam logic [7:0] CMD_STOP_MOTION = 8'h25;
  localparam logic [1:0] PHASE_1 = 2'h1;
  localparam logic [1:0] PHASE_2 = 2'h2;
  localparam logic [1:0] PHASE_3 = 2'h3;
  localparam logic [15:0] WARN_CMD_1 = 16'h095A;
  localparam logic [15:0] WARN_NONE = 16'h0000;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic STOP_DECEL = 1'b0;
  localparam logic STOP_IMMEDIATE = 1'b1;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] option;
    logic stop_method_select;
  } cmd_s;

  typedef struct packed {
    logic [7:0] code;
    logic [15:0] alarm;
    logic [7:0] status;
  } rsp_s;
endpackage

// ==== hdl/stop_ramp.sv ====
// deceleration ramp: steps speed toward zero
// assumes decel rate is static while ramping
`timescale 1ns/1ps
module stop_ramp (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic start_in,
  input wire logic immediate_in,
  input wire logic [15:0] speed_in,
  input wire logic [15:0] decel_in,
  output logic [15:0] speed_out,
  output logic done_out
);
  import stop_motion_pkg::*;

  logic active;

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      speed_out <= 16'h0000;
      active <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        active <= !immediate_in && speed_in != 16'h0000;
        speed_out <= immediate_in ? 16'h0000 : speed_in;
        done_out <= immediate_in || speed_in == 16'h0000;
      end else if (active) begin
        // a zero decel would hang the ramp, so treat it as one step
        if (speed_out <= decel_in || decel_in == 16'h0000) begin
          speed_out <= 16'h0000;
          active <= 1'b0;
          done_out <= 1'b1;
        end else begin
          speed_out <= speed_out - decel_in;
        end
      end
    end
  end
endmodule

// ==== sim/host_model.sv ====
// host side: turns a one-cycle send request into a command strobe
// assumes the bench raises send_in for exactly one cycle per command
`timescale 1ns/1ps
module host_model (
  input wire logic clk_sys_in,
  input wire logic send_in,
  input wire stop_motion_pkg::cmd_s next_cmd_in,
  input wire logic done_in,
  input wire logic [15:0] pos_in,
  output logic cmd_valid_out,
  output stop_motion_pkg::cmd_s cmd_out,
  output logic [15:0] pos_out
);
  import stop_motion_pkg::*;
  logic done_q;
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
  end
  //////////////////////////////////////////////////////////////////////////
  // fields flip between frames so a stale command never looks valid
  always @(posedge clk_sys_in) begin
    cmd_valid_out <= send_in;
    cmd_out <= send_in ? next_cmd_in : ~cmd_out;
  end
  // position is reread only once the stop is reported finished
  always @(posedge clk_sys_in) begin
    done_q <= done_in;
    if (done_in && !done_q) pos_out <= pos_in;
  end
endmodule

// ==== sim/test_stop_motion_command_handler.sv ====
// self-checking bench for the stop-motion command handler
// assumes host_model sits between the bench and the command port
`timescale 1ns/1ps
module test_stop_motion_command_handler;
  import stop_motion_pkg::*;
  logic clk_sys_in, nrst_in, send, cmd_valid, flag, cut, lc, ha, rv;
  cmd_s next_cmd, cmd;
  rsp_s rsp;
  logic [1:0] phase;
  logic [15:0] speed, decel, speed_ref, pos;
  logic [7:0] status, option;
  int bad_count, num_checks, cycles, n;
  host_model host_model_i (.clk_sys_in, .send_in(send),
    .next_cmd_in(next_cmd), .done_in(flag), .pos_in(speed_ref),
    .cmd_valid_out(cmd_valid), .cmd_out(cmd), .pos_out(pos));
  stop_motion_command_handler stop_motion_command_handler_i (
    .clk_sys_in, .nrst_in, .cmd_valid_in(cmd_valid), .cmd_in(cmd),
    .link_phase_in(phase), .speed_in(speed), .decel_param_in(decel),
    .status_in(status), .speed_ref_out(speed_ref), .output_cut_out(cut),
    .output_complete_flag_out(flag), .latch_cancel_out(lc),
    .home_return_abort_out(ha), .option_out(option),
    .rsp_valid_out(rv), .rsp_out(rsp));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // returns just after the edge on which the handler takes the command
  task automatic send_cmd(logic [7:0] c, logic s, logic [7:0] o);
    next_cmd = '{code: c, option: o, stop_method_select: s};
    send = 1'b1;
    @(posedge clk_sys_in) #1;
    send = 1'b0;
    @(posedge clk_sys_in) #1;
  endtask
  task automatic wait_done;
    n = 0;
    while (flag !== 1'b1 && n < 60) begin
      @(posedge clk_sys_in) #1;
      n++;
    end
  endtask
  task automatic t_phase1;
    phase = PHASE_1;
    send_cmd(CMD_STOP_MOTION, STOP_IMMEDIATE, 8'h3C);
    check("rsp valid", rv, 1'b1);
    check("rsp", rsp, {CMD_STOP_MOTION, WARN_CMD_1, status});
    check("ignored", {lc, ha, flag, cut}, 4'h2);
    check("option", option, 8'h00);
    check("speed kept", speed_ref, 16'h0010);
    $display("test phase1 done");
  endtask
  task automatic t_immediate;
    phase = PHASE_2;
    send_cmd(CMD_STOP_MOTION, STOP_IMMEDIATE, 8'h5A);
    check("accept", {rv, lc, flag}, 3'h6);
    check("home abort", ha, 1'b1);
    check("rsp", rsp, {CMD_STOP_MOTION, WARN_NONE, status});
    check("option", option, 8'h5A);
    wait_done();
    check("stop time", n, 2);
    @(posedge clk_sys_in) #1;
    check("cut", {cut, flag, lc, ha}, 4'hC);
    check("speed", speed_ref, 16'h0000);
    $display("test immediate done");
  endtask
  task automatic t_decel;
    phase = PHASE_3;
    speed = 16'h000A;
    decel = 16'h0003;
    send_cmd(CMD_STOP_MOTION, STOP_DECEL, 8'h00);
    check("flag low", {flag, cut, lc}, 3'h1);
    wait_done();
    // load, four steps of up to 3 from 10, then the flag
    check("ramped", n, 32'h6);
    repeat (3) @(posedge clk_sys_in) #1;
    check("held", {speed_ref, flag, cut}, {16'h0000, 2'h2});
    check("reread pos", pos, 16'h0000);
    $display("test decel done");
  endtask
  task automatic t_other_code;
    send_cmd(8'h24, STOP_IMMEDIATE, 8'h77);
    check("no rsp", {rv, lc, flag, cut}, 4'h2);
    check("option", option, 8'h00);
    $display("test other code done");
  endtask
  // the second stop lands as the first ramp ends
  task automatic t_restart;
    phase = PHASE_2;
    speed = 16'h0004;
    decel = 16'h0001;
    send_cmd(CMD_STOP_MOTION, STOP_DECEL, 8'h11);
    repeat (3) @(posedge clk_sys_in) #1;
    check("ramping", {speed_ref, flag}, {16'h0003, 1'b0});
    send_cmd(CMD_STOP_MOTION, STOP_IMMEDIATE, 8'h22);
    wait_done();
    check("restart time", n, 32'h2);
    check("restart cut", {flag, cut}, 2'h3);
    $display("test restart done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  // the tests need well under 200 cycles; 2000 means a hang
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    nrst_in = 1'b0;
    send = 1'b0;
    next_cmd = '0;
    phase = PHASE_2;
    speed = 16'h0010;
    decel = 16'h0004;
    status = 8'hA5;
    bad_count = 0;
    num_checks = 0;
    cycles = 0;
    repeat (6) @(posedge clk_sys_in);
    #1 nrst_in = 1'b1;
    check("reset", {flag, rv, lc, ha, cut}, 5'h10);
    t_phase1();
    t_immediate();
    t_decel();
    t_other_code();
    t_restart();
    print_verdict();
  end
endmodule
